// ### dwdc_pkg.sv
// Package: constants, commands and carriers for the DAC word decoder with calibration
package dwdc_pkg;

   // =====================================================
   // Sizes
   localparam int unsigned DATA_W = 14;
   localparam int unsigned NUM_CH = 32;
   localparam int unsigned CH_W = 5;
   localparam int unsigned FUNC_W = 5;

   // =====================================================
   // Reset values
   localparam logic [13:0] GAIN_RST = 14'h3ffe;
   localparam logic [13:0] OFFSET_RST = 14'h2000;
   localparam logic [13:0] OFFSET_ZERO = 14'h2000;
   localparam logic [13:0] CLR_CODE_RST = 14'h0000;
   localparam logic [13:0] INPUT_RST = 14'h0000;
   localparam logic [13:0] DAC_RST = 14'h0000;
   localparam logic [13:0] CTRL_RST = 14'h2000;
   localparam logic [13:0] CODE_MAX = 14'h3fff;
   localparam logic [5:0] MON_RST = 6'h3f;

   // =====================================================
   // Target select codes
   localparam logic [1:0] SEL_INPUT = 2'b11;
   localparam logic [1:0] SEL_OFFSET = 2'b10;
   localparam logic [1:0] SEL_GAIN = 2'b01;
   localparam logic [1:0] SEL_SPECIAL = 2'b00;

   // =====================================================
   // Special command codes
   localparam logic [4:0] FN_NOP = 5'h00;
   localparam logic [4:0] FN_WR_CLR_CODE = 5'h01;
   localparam logic [4:0] FN_SOFT_CLR = 5'h02;
   localparam logic [4:0] FN_PWR_DOWN = 5'h08;
   localparam logic [4:0] FN_PWR_UP = 5'h09;
   localparam logic [4:0] FN_MONITOR = 5'h0a;
   localparam logic [4:0] FN_CTRL = 5'h0c;
   localparam logic [4:0] FN_SOFT_RST = 5'h0f;

   // =====================================================
   // Control word fields
   localparam int unsigned CTRL_PD_HIZ_BIT = 13;
   localparam int unsigned CTRL_REF_LEVEL_BIT = 12;
   localparam int unsigned CTRL_REF_SOURCE_BIT = 10;
   localparam int unsigned CTRL_MON_EN_BIT = 9;
   localparam int unsigned MON_LSB = 8;

   // =====================================================
   // Timing (125 MHz)
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned SOFT_CLR_NS = 35000;
   localparam int unsigned PWR_UP_NS = 8000;
   localparam int unsigned SOFT_RST_NS = 135000;
   localparam int unsigned BUSY_OP_CYC = 1;
   // Least times round up
   localparam int unsigned SOFT_CLR_CYC = (SOFT_CLR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned PWR_UP_CYC = (PWR_UP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Longest time rounds down
   localparam int unsigned SOFT_RST_CYC = (SOFT_RST_NS * 1000) / CLK_PERIOD_PS;

   // =====================================================
   // Carriers
   typedef struct packed {
      logic rd_not_wr;
      logic target_select_high;
      logic target_select_low;
      logic [4:0] function_address_bits;
      logic [4:0] channel;
      logic [13:0] data_word_bits;
   } dwdc_cmd_s;

   typedef struct packed {
      logic pd_hiz;
      logic ref_level;
      logic ref_source;
   } dwdc_analog_s;

endpackage : dwdc_pkg

// ### dwdc_corrector.sv
// Per-channel gain and offset correction of an input code
`timescale 1ns/100ps
module dwdc_corrector #(
   parameter int unsigned DATA_W = 14
) (
   // Coefficients and code
   input wire logic [DATA_W-1:0] input_code_i,
   input wire logic [DATA_W-1:0] gain_i,
   input wire logic [DATA_W-1:0] offset_i,
   // Result
   output logic [DATA_W-1:0] corrected_code_o
);

   // =====================================================
   // Arithmetic
   localparam int unsigned PROD_W = 2 * DATA_W + 1;
   localparam int unsigned SUM_W = DATA_W + 3;

   wire logic [DATA_W:0] gain_plus2;
   wire logic [PROD_W-1:0] product;
   wire logic signed [SUM_W-1:0] scaled;
   wire logic signed [SUM_W-1:0] offs;
   wire logic signed [SUM_W-1:0] total;

   // Gain bit 0 is always taken as zero
   assign gain_plus2 = {1'b0, gain_i[DATA_W-1:1], 1'b0} + (DATA_W+1)'(2);
   assign product = PROD_W'(gain_plus2) * PROD_W'(input_code_i);
   assign scaled = signed'({2'b00, product[2*DATA_W:DATA_W]});
   // Offset binary: mid code means zero
   assign offs = signed'(SUM_W'(offset_i)) - signed'(SUM_W'(1 << (DATA_W-1)));
   assign total = scaled + offs;

   // Out-of-range results clip to the string ends rather than wrapping
   assign corrected_code_o = total[SUM_W-1] ? '0 :
                             (total > signed'(SUM_W'({DATA_W{1'b1}}))) ? {DATA_W{1'b1}} :
                             total[DATA_W-1:0];

endmodule : dwdc_corrector

// ### dwdc_core.sv
// Data word decoder, calibration store and special command executor for a 32-channel DAC
// Notes on behaviour
// - Corrected code is (gain+2)/2^14 times input plus offset minus 2^13.
// - Gain defaults to 3FFE; bit 0 is always treated as zero.
// - Offset coefficient defaults to 2000, meaning no correction.
// - All channels double buffered; load strobe updates every output together.
// - Select 11 input, 10 offset, 01 gain, 00 special commands.
// - Input codes are straight binary.
// - Offset codes are offset binary around 2000.
// - Gain scales linearly, full code equals unity.
// - Special space decodes the five function address bits.
// - Decode nop, clear code, soft clear, power down/up, monitor, control, reset.
// - No operation changes nothing but pulses busy low.
// - Write clear code stores the data; clear code resets to zero.
// - Clear input low or soft clear loads clear code into all DAC registers.
// - Soft clear holds busy low for 35 us.
// - Soft power down idles all channels; amplifier state from control bit.
// - Powered down keeps all registers and rejects every write except power-up.
// - Reference source bit picks internal; level bit only matters when internal.
// - Power up takes 8 us; software and hardware power down are ORed.
// - Soft reset restores defaults, zeroes DAC registers, within 135 us.
`timescale 1ns/100ps
module dwdc_core #(
   parameter int unsigned NUM_CH = dwdc_pkg::NUM_CH,
   parameter int unsigned SOFT_RST_CYC = dwdc_pkg::SOFT_RST_CYC
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Host word port
   input wire logic cmd_valid_i,
   input wire dwdc_pkg::dwdc_cmd_s cmd_i,
   output logic busy_n_o,
   output logic [13:0] read_data_o,
   output logic read_valid_o,
   // Hardware controls
   input wire logic output_load_strobe_n_i,
   input wire logic clear_input_n_i,
   input wire logic hw_power_down_i,
   // Converter side
   output logic [NUM_CH*14-1:0] dac_codes_o,
   output logic power_down_o,
   output dwdc_pkg::dwdc_analog_s analog_o,
   output logic [5:0] monitor_select_o,
   output logic monitor_enable_o
);

   // =====================================================
   // Types and storage
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_BUSY = 4'b0010,
      ST_CLEAR = 4'b0100,
      ST_RESET = 4'b1000
   } dwdc_state_e;

   // The counter must hold the longest wait, whatever length the soft reset is given
   localparam int unsigned CNT_MAX = (SOFT_RST_CYC > dwdc_pkg::SOFT_CLR_CYC) ?
                                     ((SOFT_RST_CYC > dwdc_pkg::PWR_UP_CYC) ? SOFT_RST_CYC : dwdc_pkg::PWR_UP_CYC) :
                                     ((dwdc_pkg::SOFT_CLR_CYC > dwdc_pkg::PWR_UP_CYC) ? dwdc_pkg::SOFT_CLR_CYC :
                                      dwdc_pkg::PWR_UP_CYC);
   localparam int unsigned CNT_W = $clog2(CNT_MAX + 1);
   localparam logic [CNT_W-1:0] CNT_CLR = CNT_W'(dwdc_pkg::SOFT_CLR_CYC);
   localparam logic [CNT_W-1:0] CNT_PWR = CNT_W'(dwdc_pkg::PWR_UP_CYC);
   localparam logic [CNT_W-1:0] CNT_RST = CNT_W'(SOFT_RST_CYC);
   localparam logic [CNT_W-1:0] CNT_OP = CNT_W'(dwdc_pkg::BUSY_OP_CYC);

   dwdc_state_e state_q;
   dwdc_state_e state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [13:0] input_q [NUM_CH];
   logic [13:0] gain_q [NUM_CH];
   logic [13:0] offset_q [NUM_CH];
   logic [13:0] dac_q [NUM_CH];
   logic [13:0] clr_code_q;
   logic [13:0] ctrl_q;
   logic [5:0] mon_q;
   logic soft_pd_q;
   logic [13:0] read_data_q;
   logic read_valid_q;

   // =====================================================
   // Decode
   wire logic [1:0] sel;
   wire logic accept;
   wire logic powered_down;
   wire logic wr_ok;
   wire logic is_special;
   wire logic [4:0] fn;
   wire logic fn_wr_clr;
   wire logic fn_soft_clr;
   wire logic fn_pd;
   wire logic fn_pu;
   wire logic fn_mon;
   wire logic fn_ctrl_wr;
   wire logic fn_ctrl_rd;
   wire logic fn_rst;
   wire logic wr_input;
   wire logic wr_offset;
   wire logic wr_gain;
   wire logic load_now;
   wire logic clear_now;
   wire logic reset_now;

   assign sel = {cmd_i.target_select_high, cmd_i.target_select_low};
   // Words are taken only while idle; the host watches busy
   assign accept = cmd_valid_i && (state_q == ST_IDLE);
   assign powered_down = soft_pd_q || hw_power_down_i;
   // Power-up is a command, not a register write, so it passes while down
   assign wr_ok = accept && !powered_down && !cmd_i.rd_not_wr;
   assign is_special = (sel == dwdc_pkg::SEL_SPECIAL);
   assign fn = cmd_i.function_address_bits;
   assign fn_wr_clr = wr_ok && is_special && (fn == dwdc_pkg::FN_WR_CLR_CODE);
   assign fn_soft_clr = wr_ok && is_special && (fn == dwdc_pkg::FN_SOFT_CLR);
   assign fn_pd = wr_ok && is_special && (fn == dwdc_pkg::FN_PWR_DOWN);
   assign fn_pu = accept && !cmd_i.rd_not_wr && is_special && (fn == dwdc_pkg::FN_PWR_UP);
   assign fn_mon = wr_ok && is_special && (fn == dwdc_pkg::FN_MONITOR);
   assign fn_ctrl_wr = wr_ok && is_special && (fn == dwdc_pkg::FN_CTRL);
   // Reads pass in power down; only writes are refused
   assign fn_ctrl_rd = accept && cmd_i.rd_not_wr && is_special && (fn == dwdc_pkg::FN_CTRL);
   assign fn_rst = wr_ok && is_special && (fn == dwdc_pkg::FN_SOFT_RST);
   assign wr_input = wr_ok && (sel == dwdc_pkg::SEL_INPUT);
   assign wr_offset = wr_ok && (sel == dwdc_pkg::SEL_OFFSET);
   assign wr_gain = wr_ok && (sel == dwdc_pkg::SEL_GAIN);
   // Defaults come back on the last cycle of the wait, as busy rises
   assign reset_now = (state_q == ST_RESET) && (cnt_q == CNT_RST - CNT_W'(1));
   assign clear_now = !clear_input_n_i || fn_soft_clr;
   assign load_now = !output_load_strobe_n_i;

   // =====================================================
   // Sequencer
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         ST_IDLE: begin
            cnt_d = '0;
            if (fn_rst) begin
               state_d = ST_RESET;
            end else if (fn_soft_clr) begin
               state_d = ST_CLEAR;
            end else if (fn_pu) begin
               state_d = ST_BUSY;
               cnt_d = CNT_OP - CNT_PWR; // Wraps so that count reaches CNT_OP after the power-up time
            end else if (accept) begin
               // Every other word, nop and unknown codes included, pulses busy
               state_d = ST_BUSY;
               cnt_d = '0;
            end
         end
         ST_BUSY: begin
            // Ordinary words and the power-up wait share this state
            cnt_d = cnt_q + CNT_W'(1);
            if (cnt_q == CNT_OP - CNT_W'(1)) begin
               state_d = ST_IDLE;
            end
         end
         ST_CLEAR: begin
            // Outputs already hold the clear code; busy covers the whole settling time
            cnt_d = cnt_q + CNT_W'(1);
            if (cnt_q == CNT_CLR - CNT_W'(1)) begin
               state_d = ST_IDLE;
            end
         end
         ST_RESET: begin
            // Exactly the reset count of cycles, so the wait never exceeds its limit
            cnt_d = cnt_q + CNT_W'(1);
            if (cnt_q == CNT_RST - CNT_W'(1)) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
            cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // =====================================================
   // Per channel storage and correction
   generate
      for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
         wire logic hit;
         wire logic [13:0] corrected;
         wire logic dac_en;
         wire logic [13:0] dac_d;
         assign hit = (cmd_i.channel == dwdc_pkg::CH_W'(ch));
         // Clear beats a coincident load
         assign dac_en = clear_now || load_now;
         assign dac_d = clear_now ? clr_code_q : corrected;

         dwdc_corrector #(
            .DATA_W(14)
         ) u_corr (
            .input_code_i(input_q[ch]),
            .gain_i(gain_q[ch]),
            .offset_i(offset_q[ch]),
            .corrected_code_o(corrected)
         );

         // First buffer stage: input code and coefficients
         always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i || reset_now) begin
               input_q[ch] <= dwdc_pkg::INPUT_RST;
               gain_q[ch] <= dwdc_pkg::GAIN_RST;
               offset_q[ch] <= dwdc_pkg::OFFSET_RST;
            end else begin
               if (wr_input && hit) begin
                  input_q[ch] <= cmd_i.data_word_bits;
               end
               if (wr_gain && hit) begin
                  gain_q[ch] <= {cmd_i.data_word_bits[13:1], 1'b0};
               end
               if (wr_offset && hit) begin
                  offset_q[ch] <= cmd_i.data_word_bits;
               end
            end
         end

         // Second stage: only a strobe, a clear or a reset moves codes to the string, all channels at once
         always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i || reset_now) begin
               dac_q[ch] <= dwdc_pkg::DAC_RST;
            end else if (dac_en) begin
               dac_q[ch] <= dac_d;
            end
         end
         assign dac_codes_o[ch*14 +: 14] = dac_q[ch];
      end
   endgenerate

   // =====================================================
   // Shared registers
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || reset_now) begin
         clr_code_q <= dwdc_pkg::CLR_CODE_RST;
         ctrl_q <= dwdc_pkg::CTRL_RST;
         mon_q <= dwdc_pkg::MON_RST;
         soft_pd_q <= 1'b0;
      end else begin
         if (fn_wr_clr) begin
            clr_code_q <= cmd_i.data_word_bits;
         end
         if (fn_ctrl_wr) begin
            ctrl_q <= cmd_i.data_word_bits;
         end
         if (fn_mon) begin
            mon_q <= cmd_i.data_word_bits[13:dwdc_pkg::MON_LSB];
         end
         // Soft power-down stands until a power-up word or a reset
         if (fn_pd) begin
            soft_pd_q <= 1'b1;
         end else if (fn_pu) begin
            soft_pd_q <= 1'b0;
         end
      end
   end

   // =====================================================
   // Control read-back
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         read_data_q <= '0;
         read_valid_q <= 1'b0;
      end else begin
         read_valid_q <= fn_ctrl_rd;
         if (fn_ctrl_rd) begin
            read_data_q <= ctrl_q;
         end
      end
   end

   // =====================================================
   // Outputs
   assign busy_n_o = (state_q == ST_IDLE);
   assign read_data_o = read_data_q;
   assign read_valid_o = read_valid_q;
   assign power_down_o = powered_down;
   assign analog_o.pd_hiz = ctrl_q[dwdc_pkg::CTRL_PD_HIZ_BIT];
   assign analog_o.ref_source = ctrl_q[dwdc_pkg::CTRL_REF_SOURCE_BIT];
   // Level is meaningless with an external reference, so it is masked
   assign analog_o.ref_level = ctrl_q[dwdc_pkg::CTRL_REF_SOURCE_BIT] &&
                               ctrl_q[dwdc_pkg::CTRL_REF_LEVEL_BIT];
   assign monitor_select_o = mon_q;
   assign monitor_enable_o = ctrl_q[dwdc_pkg::CTRL_MON_EN_BIT];

endmodule : dwdc_core

// ### dwdc_core_checker.sv
// Concurrent checks on the ports of the DAC word decoder core
`timescale 1ns/100ps
module dwdc_core_checker #(
   parameter int unsigned NUM_CH = 32,
   parameter int unsigned SOFT_RST_CYC = 16875
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Host word port
   input wire logic cmd_valid_i,
   input wire dwdc_pkg::dwdc_cmd_s cmd_i,
   input wire logic busy_n_o,
   input wire logic [13:0] read_data_o,
   input wire logic read_valid_o,
   // Hardware controls
   input wire logic output_load_strobe_n_i,
   input wire logic clear_input_n_i,
   input wire logic hw_power_down_i,
   // Converter side
   input wire logic [NUM_CH*14-1:0] dac_codes_o,
   input wire logic power_down_o,
   input wire dwdc_pkg::dwdc_analog_s analog_o,
   input wire logic [5:0] monitor_select_o,
   input wire logic monitor_enable_o
);
   // ==========================================
   // Busy run length and kind of the last word taken
   logic [15:0] low_cnt_q;
   logic [7:0] kind_q;
   wire logic take = cmd_valid_i && busy_n_o;
   wire logic sp = !cmd_i.target_select_high && !cmd_i.target_select_low;
   wire logic [4:0] fn = kind_q[4:0];
   wire logic sfn = kind_q[6] && !kind_q[5];
   // Rejected in power down, so they are long only when taken while powered up
   wire logic clr_w = sfn && !kind_q[7] && fn == dwdc_pkg::FN_SOFT_CLR;
   wire logic rst_w = sfn && !kind_q[7] && fn == dwdc_pkg::FN_SOFT_RST;
   wire logic pup_w = sfn && fn == dwdc_pkg::FN_PWR_UP;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         low_cnt_q <= 16'h0000;
         kind_q <= 8'h00;
      end else begin
         low_cnt_q <= busy_n_o ? 16'h0000 : low_cnt_q + 16'h0001;
         if (take) kind_q <= {power_down_o, sp, cmd_i.rd_not_wr, cmd_i.function_address_bits};
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================
   // Assertions
   chk_busy_on_take: assert property (take |=> !busy_n_o) else $error("busy not low after word");
   chk_word_one_low: assert property ($rose(busy_n_o) && !(clr_w || rst_w || pup_w) |-> low_cnt_q == 16'h0001)
      else $error("ordinary word busy not one cycle");
   chk_soft_clr_len: assert property ($rose(busy_n_o) && clr_w |-> low_cnt_q == 16'h1117)
      else $error("soft clear busy length wrong");
   chk_pwr_up_len: assert property ($rose(busy_n_o) && pup_w |-> low_cnt_q == 16'h03e8)
      else $error("power up busy length wrong");
   chk_soft_rst_len: assert property ($rose(busy_n_o) && rst_w |-> int'(low_cnt_q) == SOFT_RST_CYC)
      else $error("soft reset busy length wrong");
   chk_ctrl_read: assert property (take && sp && cmd_i.rd_not_wr
      && cmd_i.function_address_bits == dwdc_pkg::FN_CTRL |=> read_valid_o ##1 !read_valid_o)
      else $error("read pulse wrong");
   chk_clear_all: assert property (!clear_input_n_i |=> dac_codes_o == {NUM_CH{dac_codes_o[13:0]}})
      else $error("clear left channels unequal");
   chk_dac_hold: assert property (output_load_strobe_n_i && clear_input_n_i && busy_n_o && !cmd_valid_i
      |=> $stable(dac_codes_o)) else $error("outputs moved without load");
   chk_hw_pd_or: assert property (hw_power_down_i |-> power_down_o) else $error("hw power down ignored");
   chk_ref_level: assert property (!analog_o.ref_source |-> !analog_o.ref_level)
      else $error("level set with external ref");
endmodule : dwdc_core_checker

bind dwdc_core dwdc_core_checker #(.NUM_CH(NUM_CH), .SOFT_RST_CYC(SOFT_RST_CYC)) u_dwdc_core_checker (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
   .busy_n_o(busy_n_o), .read_data_o(read_data_o), .read_valid_o(read_valid_o),
   .output_load_strobe_n_i(output_load_strobe_n_i), .clear_input_n_i(clear_input_n_i),
   .hw_power_down_i(hw_power_down_i), .dac_codes_o(dac_codes_o), .power_down_o(power_down_o),
   .analog_o(analog_o), .monitor_select_o(monitor_select_o), .monitor_enable_o(monitor_enable_o));

// ### dwdc_host_model.sv
// Host model that issues command words over the word port
`timescale 1ns/100ps
module dwdc_host_model (
   // Clock
   input wire logic clk_sys_i,
   // Word port
   input wire logic busy_n_i,
   output logic cmd_valid_o,
   output dwdc_pkg::dwdc_cmd_s cmd_o
);
   int n_to = 0;
   initial begin
      cmd_valid_o = 1'b0;
      cmd_o = '0;
   end
   // Called just after an edge; words while busy are dropped, so wait for idle
   task automatic send(input dwdc_pkg::dwdc_cmd_s c);
      int n;
      n = 0;
      cmd_o = c;
      cmd_valid_o = 1'b1;
      while (busy_n_i !== 1'b1 && n < 20000) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      if (n >= 20000) n_to++;
      @(posedge clk_sys_i);
      #1;
      cmd_valid_o = 1'b0;
      // Stale inverted bits so nothing leans on old data
      cmd_o = ~c;
   endtask : send
endmodule : dwdc_host_model

// ### dac_word_decoder_calibration_tb_top.sv
// Self-checking testbench for the DAC word decoder with calibration
`timescale 1ns/100ps
module dac_word_decoder_calibration_tb_top;
   // ==========================================
   // Signals and instances
   localparam logic [1:0] SI = dwdc_pkg::SEL_INPUT;
   localparam logic [1:0] SO = dwdc_pkg::SEL_OFFSET;
   localparam logic [1:0] SG = dwdc_pkg::SEL_GAIN;
   localparam logic [1:0] SS = dwdc_pkg::SEL_SPECIAL;
   logic clk_sys_i;
   logic rst_n_i = 1'b0;
   logic ld_n = 1'b1;
   logic clr_n = 1'b1;
   logic hw_pd = 1'b0;
   logic cmd_valid;
   dwdc_pkg::dwdc_cmd_s cmd;
   logic busy_n;
   logic [13:0] rd_data;
   logic rd_valid;
   logic [447:0] dac;
   logic pd;
   dwdc_pkg::dwdc_analog_s ana;
   logic [5:0] mon;
   logic mon_en;
   int num_errors = 0;
   int n_tests = 0;
   // Short soft reset keeps the run brief
   dwdc_core #(.NUM_CH(32), .SOFT_RST_CYC(20)) u_dwdc_core (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .busy_n_o(busy_n),
      .read_data_o(rd_data), .read_valid_o(rd_valid), .output_load_strobe_n_i(ld_n), .clear_input_n_i(clr_n),
      .hw_power_down_i(hw_pd), .dac_codes_o(dac), .power_down_o(pd), .analog_o(ana),
      .monitor_select_o(mon), .monitor_enable_o(mon_en));
   dwdc_host_model u_dwdc_host_model (.clk_sys_i(clk_sys_i), .busy_n_i(busy_n), .cmd_valid_o(cmd_valid), .cmd_o(cmd));
   // ==========================================
   // Helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic idle();
      int n;
      n = 0;
      while (busy_n !== 1'b1 && n < 20000) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      if (n >= 20000) begin
         num_errors++;
         stop_test();
      end
   endtask : idle
   task automatic word(input logic [1:0] s, input logic [4:0] f, input logic [4:0] ch, input logic [13:0] d);
      u_dwdc_host_model.send({1'b0, s, f, ch, d});
      idle();
   endtask : word
   task automatic strobe(input bit clr);
      if (clr) clr_n = 1'b0;
      else ld_n = 1'b0;
      @(posedge clk_sys_i);
      #1;
      if (clr) clr_n = 1'b1;
      else ld_n = 1'b1;
   endtask : strobe
   function automatic logic [13:0] dc(input int ch);
      return dac[ch*14+:14];
   endfunction : dc
   // ==========================================
   // Scenarios
   task automatic t_defaults();
      chk(mon, 6'h3f);
      chk(ana, 3'h4);
      word(SI, 5'h00, 5'h05, 14'h1234);
      chk(dc(5), 14'h0000);
      word(SI, 5'h00, 5'h1f, 14'h3fff);
      strobe(0);
      chk(dc(5), 14'h1234);
      chk(dc(31), 14'h3fff);
   endtask : t_defaults
   task automatic t_calib();
      word(SG, 5'h00, 5'h02, 14'h0001);
      word(SI, 5'h00, 5'h02, 14'h3fff);
      word(SO, 5'h00, 5'h03, 14'h3fff);
      word(SI, 5'h00, 5'h03, 14'h1000);
      word(SG, 5'h00, 5'h04, 14'h1ffe);
      word(SI, 5'h00, 5'h04, 14'h2000);
      word(SO, 5'h00, 5'h04, 14'h2005);
      word(SO, 5'h00, 5'h06, 14'h0000);
      word(SI, 5'h00, 5'h06, 14'h3000);
      strobe(0);
      chk(dc(2), 14'h0001);
      chk(dc(3), 14'h2fff);
      chk(dc(4), 14'h1005);
      chk(dc(6), 14'h1000);
   endtask : t_calib
   task automatic t_clear();
      word(SS, dwdc_pkg::FN_WR_CLR_CODE, 5'h00, 14'h0155);
      strobe(1);
      for (int i = 0; i < 32; i++) chk(dc(i), 14'h0155);
      strobe(0);
      chk(dc(5), 14'h1234);
      word(SS, dwdc_pkg::FN_WR_CLR_CODE, 5'h00, 14'h2aaa);
      word(SS, dwdc_pkg::FN_SOFT_CLR, 5'h00, 14'h0000);
      chk(dc(31), 14'h2aaa);
   endtask : t_clear
   task automatic t_ctrl();
      word(SS, dwdc_pkg::FN_CTRL, 5'h00, 14'h1400);
      chk(ana, 3'h3);
      u_dwdc_host_model.send({1'b1, SS, dwdc_pkg::FN_CTRL, 5'h00, 14'h0000});
      chk({rd_valid, rd_data}, 15'h5400);
      idle();
      word(SS, dwdc_pkg::FN_CTRL, 5'h00, 14'h3200);
      chk({ana, mon_en}, 4'h9);
      word(SS, dwdc_pkg::FN_MONITOR, 5'h00, 14'h0500);
      chk(mon, 6'h05);
   endtask : t_ctrl
   task automatic t_noop();
      logic [4:0] codes [6];
      codes = '{5'h00, 5'h03, 5'h07, 5'h0b, 5'h0e, 5'h1f};
      foreach (codes[i]) word(SS, codes[i], 5'h05, 14'h3fff);
      strobe(0);
      chk({mon, dc(5)}, 20'h1_5234);
      strobe(1);
      chk(dc(9), 14'h2aaa);
   endtask : t_noop
   task automatic t_power();
      word(SS, dwdc_pkg::FN_PWR_DOWN, 5'h00, 14'h0000);
      chk(pd, 1'b1);
      word(SI, 5'h00, 5'h05, 14'h0777);
      word(SS, dwdc_pkg::FN_MONITOR, 5'h00, 14'h0900);
      strobe(0);
      chk({mon, dc(5)}, 20'h1_5234);
      word(SS, dwdc_pkg::FN_PWR_UP, 5'h00, 14'h0000);
      chk(pd, 1'b0);
      hw_pd = 1'b1;
      @(posedge clk_sys_i);
      #1;
      chk(pd, 1'b1);
      hw_pd = 1'b0;
   endtask : t_power
   task automatic t_reset();
      word(SS, dwdc_pkg::FN_SOFT_RST, 5'h00, 14'h0000);
      chk({dc(5), dc(31)}, 28'h000_0000);
      chk({ana, mon_en, mon}, 10'h23f);
      word(SI, 5'h00, 5'h04, 14'h0800);
      strobe(0);
      chk(dc(4), 14'h0800);
      strobe(1);
      chk(dc(4), 14'h0000);
   endtask : t_reset
   // ==========================================
   // Run control
   task automatic stop_test();
      num_errors += u_dwdc_host_model.n_to;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (16) @(posedge clk_sys_i);
      #1;
      rst_n_i = 1'b1;
      chk(busy_n, 1'b1);
      t_defaults();
      t_calib();
      t_clear();
      t_ctrl();
      t_noop();
      t_power();
      t_reset();
      stop_test();
   end
endmodule : dac_word_decoder_calibration_tb_top
